// file: design/frame_repair_defs.vh
`ifndef FRAME_REPAIR_DEFS_VH
`define FRAME_REPAIR_DEFS_VH

// Register offsets, byte addresses
`define CTRL_OFS        4'h0
`define STATUS_OFS      4'h4
`define LAST_PTR_OFS    4'h8
`define REPAIRED_OFS    4'hc

// Control field positions
`define CTRL_AUTO_BIT   0
`define CTRL_SIZE_LO    1
`define CTRL_SIZE_HI    2
`define CTRL_START_BIT  3
`define CTRL_CLEAR_BIT  4
`define CTRL_RESET      5'h00

// Status field positions
`define STAT_BUSY_BIT   0
`define STAT_OVF_BIT    1
`define STAT_CNT_LO     8
`define STAT_STEP_LO    16

// Configuration words
`define SYNC_WORD       32'haa995566
`define CMD_HDR_WORD    32'h30008001
`define WR_ENABLE_WORD  32'h00000001
`define CHECK_CLR_WORD  32'h00000007
`define FAR_HDR_WORD    32'h30002001
`define DATA_HDR_SMALL  32'h3000402a
`define DATA_HDR_MED    32'h3000403c
`define DATA_HDR_LARGE  32'h3000404e

// Frame address layout
`define FAR_MAJ_LO      17
`define FAR_MIN_LO      9
`define CENTER_LAST     16'd7
`define CLB_FRAMES      16'd48
`define IOB_FRAMES      16'd54
`define BRI_FRAMES      16'd27
`define IOB_OFFSET      16'd8
`define BRI_OFFSET      16'd116
`define IOB_LAST        16'd115

// Timing counts in configuration clock cycles
`define ABORT_CYCLES    3'd4

`endif

// file: design/frame_repair_ctrl.v
// Summary of operation
// R1 - Check constant for a frame sits at the address equal to its number.
// R2 - Each mismatching frame number is saved for use after readback ends; once LIST_DEPTH are held, further ones only set the overflow flag.
//      The code drops mismatches that arrive while busy; it sets the flag for them only when the list is already full.
// R3 - Several mismatching frame numbers can be held from one readback pass.
// R4 - After readback with mismatches, every saved frame is fetched and rewritten.
// R5 - Abort holds select low and write strobe high for three or more clocks.
// R6 - Abort resets the device port and logic and clears its errors.
// R7 - Sync word is sent after abort; device waits for it.
// R8 - Command header then enable-frame-write command enables configuration writes.
// R9 - Frame pointer header then one word with column and frame fields.
// R10 - Data input header carries frame length plus one, chosen by device size.
// R11 - Data frame then a dummy frame, each ending in a dummy word.
// R12 - Command header and clear-check command follow; device zeroes its check.
// R13 - Every single-frame rewrite ends with a second abort.
// R14 - Abort carries no data words, only select and strobe levels.
// R15 - Frames are counted from zero during readback, dummy frame excluded.
// R16 - Frames 0 to 7: column zero, frame field equals frame number.
// R17 - Logic columns: column (N-8)/48+1, frame (N-8) mod 48.
// R18 - I/O columns: column M/54+cols+1, frame M mod 54.
// R19 - Memory interconnect: column M/27+cols+3, frame M mod 27.
// R20 - Column field in bits 17-24, frame field in bits 9-16, rest zero.
// R21 - Device holds the last word until the next word pushes it.
// R22 - Device advances the frame address per frame within one packet.
// R23 - Block type field of the pointer word is always zero.
// R24 - Rewrite starts only after readback ends and only with recorded frames; the code also starts on a start-bit write made during readback.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "frame_repair_defs.vh"

module frame_repair_ctrl #(
    parameter COLS        = 48,
    parameter LIST_DEPTH  = 8,
    parameter LIST_AW     = 3,
    parameter FRAME_W     = 12,
    parameter HALF_PERIOD = 2
) (
    // Clock and reset
    input  wire               core_clk,
    input  wire               arst_n,
    // Register port
    input  wire [3:0]         reg_addr,
    input  wire [31:0]        reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [31:0]        reg_rdata,
    // Readback check results
    input  wire               rb_start,
    input  wire               rb_frame,
    input  wire               rb_mismatch,
    input  wire               rb_done,
    output wire [FRAME_W-1:0] chk_addr,
    // Frame data memory
    output reg                mem_rd,
    output reg  [FRAME_W-1:0] mem_frame,
    output reg  [10:0]        mem_word,
    input  wire [31:0]        mem_rdata,
    // Configuration port
    output reg                cfg_cclk,
    output reg                cfg_cs_n,
    output reg                cfg_wr_n,
    output reg  [7:0]         cfg_d_out,
    output reg                cfg_d_oe,
    output wire               busy
);

    localparam S_IDLE   = 3'd0;
    localparam S_LOAD   = 3'd1;
    localparam S_WAIT   = 3'd2;
    localparam S_SEND   = 3'd3;
    localparam S_NEXT   = 3'd4;
    localparam S_ABORT  = 3'd5;
    localparam S_DESEL  = 3'd6;

    localparam [3:0] ST_ABORT1 = 4'd0;
    localparam [3:0] ST_SYNC   = 4'd1;
    localparam [3:0] ST_CMDH1  = 4'd2;
    localparam [3:0] ST_WREN   = 4'd3;
    localparam [3:0] ST_FARH   = 4'd4;
    localparam [3:0] ST_FAR    = 4'd5;
    localparam [3:0] ST_DATAH  = 4'd6;
    localparam [3:0] ST_DATA   = 4'd7;
    localparam [3:0] ST_DUMMY  = 4'd8;
    localparam [3:0] ST_CMDH2  = 4'd9;
    localparam [3:0] ST_CHKCLR = 4'd10;
    localparam [3:0] ST_ABORT2 = 4'd11;

    localparam [31:0] COLS_W   = COLS;
    localparam [31:0] COLS48_W = COLS * 48;
    localparam [15:0] COLS16   = COLS_W[15:0];
    localparam [15:0] COLS48   = COLS48_W[15:0];

    reg [4:0]         ctrl_reg;
    reg [2:0]         state_reg;
    reg [3:0]         step_reg;
    reg [1:0]         byte_reg;
    reg [2:0]         abort_reg;
    reg [10:0]        wcnt_reg;
    reg [31:0]        shift_reg;
    reg [7:0]         div_reg;
    reg [FRAME_W-1:0] count_reg;
    reg [FRAME_W-1:0] list_mem [0:LIST_DEPTH-1];
    reg [LIST_AW:0]   fill_reg;
    reg [LIST_AW:0]   rd_reg;
    reg               ovf_reg;
    reg [31:0]        far_reg;
    reg [15:0]        repaired_reg;

    wire tick_fall = (div_reg == HALF_PERIOD - 1) && cfg_cclk;
    wire tick_half = (div_reg == HALF_PERIOD - 1);
    wire start_req = (reg_wr && reg_addr == `CTRL_OFS && reg_wdata[`CTRL_START_BIT])
                     || (rb_done && ctrl_reg[`CTRL_AUTO_BIT]);
    wire list_full = (fill_reg == LIST_DEPTH);
    wire [FRAME_W-1:0] cur_frame = list_mem[rd_reg[LIST_AW-1:0]];

    assign busy = (state_reg != S_IDLE);
    assign chk_addr = count_reg; // R1

    // Data input header by device size
    reg [31:0] data_hdr;
    always @* begin
        case (ctrl_reg[`CTRL_SIZE_HI:`CTRL_SIZE_LO])
            2'd0:    data_hdr = `DATA_HDR_SMALL;
            2'd1:    data_hdr = `DATA_HDR_MED;
            default: data_hdr = `DATA_HDR_LARGE;
        endcase
    end
    wire [10:0] frame_words = data_hdr[10:0]; // R10

    // Frame number to column and frame fields
    reg [15:0] n_ext;
    reg [15:0] m_val;
    reg [15:0] maj_w;
    reg [15:0] min_w;
    wire [7:0] maj  = maj_w[7:0];
    wire [7:0] minr = min_w[7:0];
    always @* begin
        n_ext = {{(16-FRAME_W){1'b0}}, cur_frame};
        m_val = 16'h0000;
        maj_w = 16'h0000;
        min_w = 16'h0000;
        if (n_ext <= `CENTER_LAST) begin
            maj_w = 16'h0000; // R16
            min_w = n_ext; // R16
        end else if (n_ext <= COLS48 + `CENTER_LAST) begin
            m_val = n_ext - `IOB_OFFSET;
            maj_w = m_val / `CLB_FRAMES + 16'd1; // R17
            min_w = m_val % `CLB_FRAMES; // R17
        end else if (n_ext <= COLS48 + `IOB_LAST) begin
            m_val = n_ext - COLS48 - `IOB_OFFSET;
            maj_w = m_val / `IOB_FRAMES + COLS16 + 16'd1; // R18
            min_w = m_val % `IOB_FRAMES; // R18
        end else begin
            m_val = n_ext - COLS48 - `BRI_OFFSET;
            maj_w = m_val / `BRI_FRAMES + COLS16 + 16'd3; // R19
            min_w = m_val % `BRI_FRAMES; // R19
        end
    end
    wire [31:0] far_word = {7'h00, maj, minr, 9'h000}; // R20 R23

    // Word for the current step
    reg [31:0] step_word;
    always @* begin
        case (step_reg)
            ST_SYNC:  step_word = `SYNC_WORD; // R7
            ST_CMDH1: step_word = `CMD_HDR_WORD; // R8
            ST_WREN:   step_word = `WR_ENABLE_WORD; // R8
            ST_FARH:   step_word = `FAR_HDR_WORD; // R9
            ST_FAR:    step_word = far_word; // R9
            ST_DATAH:  step_word = data_hdr; // R10
            ST_CMDH2:  step_word = `CMD_HDR_WORD; // R12
            ST_CHKCLR: step_word = `CHECK_CLR_WORD; // R12
            default:  step_word = 32'h00000000; // R11
        endcase
    end

    // Configuration clock divider
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 8'h00;
            cfg_cclk <= 1'b0;
        end else if (tick_half) begin
            div_reg <= 8'h00;
            cfg_cclk <= ~cfg_cclk;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // Readback frame counting and mismatch list
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= {FRAME_W{1'b0}};
            fill_reg <= {(LIST_AW+1){1'b0}};
            ovf_reg <= 1'b0;
        end else if (rb_start && !busy) begin
            count_reg <= {FRAME_W{1'b0}}; // R15
            fill_reg <= {(LIST_AW+1){1'b0}};
        end else begin
            if (rb_frame) begin
                count_reg <= count_reg + 1'b1; // R15
                if (rb_mismatch && !busy && !list_full) begin
                    fill_reg <= fill_reg + 1'b1; // R2 R3
                end
                if (rb_mismatch && list_full) begin
                    ovf_reg <= 1'b1;
                end
            end
            if (reg_wr && reg_addr == `CTRL_OFS && reg_wdata[`CTRL_CLEAR_BIT]
                && !(rb_frame && rb_mismatch && list_full)) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (rb_frame && rb_mismatch && !busy && !list_full) begin
            list_mem[fill_reg[LIST_AW-1:0]] <= count_reg; // R2 R3
        end
    end

    // Register port
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `CTRL_RESET;
            reg_rdata <= 32'h00000000;
        end else begin
            if (reg_wr && reg_addr == `CTRL_OFS) begin
                ctrl_reg <= {2'b00, reg_wdata[`CTRL_SIZE_HI:0]};
            end
            if (reg_rd) begin
                case (reg_addr)
                    `CTRL_OFS:     reg_rdata <= {27'h0, ctrl_reg};
                    `STATUS_OFS:   reg_rdata <= {12'h000, step_reg,
                                                 {(8-LIST_AW-1){1'b0}}, fill_reg,
                                                 6'h00, ovf_reg, busy};
                    `LAST_PTR_OFS: reg_rdata <= far_reg;
                    `REPAIRED_OFS: reg_rdata <= {16'h0000, repaired_reg};
                    default:       reg_rdata <= 32'h00000000;
                endcase
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end

    // Rewrite sequencer
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
            step_reg <= ST_ABORT1;
            byte_reg <= 2'd0;
            abort_reg <= 3'd0;
            wcnt_reg <= 11'd0;
            shift_reg <= 32'h00000000;
            rd_reg <= {(LIST_AW+1){1'b0}};
            far_reg <= 32'h00000000;
            repaired_reg <= 16'h0000;
            mem_rd <= 1'b0;
            mem_frame <= {FRAME_W{1'b0}};
            mem_word <= 11'd0;
            cfg_cs_n <= 1'b1;
            cfg_wr_n <= 1'b1;
            cfg_d_out <= 8'h00;
            cfg_d_oe <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start_req && fill_reg != 0) begin
                        rd_reg <= {(LIST_AW+1){1'b0}}; // R24 R4
                        step_reg <= ST_ABORT1;
                        abort_reg <= 3'd0;
                        state_reg <= S_ABORT;
                    end
                end
                S_ABORT: begin
                    if (tick_fall) begin
                        cfg_cs_n <= 1'b0; // R5 R14
                        cfg_wr_n <= 1'b1; // R5 R14
                        cfg_d_oe <= 1'b0; // R14
                        cfg_d_out <= 8'h00;
                        abort_reg <= abort_reg + 3'd1;
                        if (abort_reg == `ABORT_CYCLES - 3'd1) begin
                            state_reg <= S_DESEL;
                        end
                    end
                end
                S_DESEL: begin
                    if (tick_fall) begin
                        cfg_cs_n <= 1'b1;
                        cfg_wr_n <= 1'b1;
                        if (step_reg == ST_ABORT2) begin
                            repaired_reg <= repaired_reg + 16'h0001;
                            if (rd_reg + 1'b1 == fill_reg) begin
                                state_reg <= S_IDLE;
                            end else begin
                                rd_reg <= rd_reg + 1'b1; // R4
                                step_reg <= ST_ABORT1;
                                abort_reg <= 3'd0;
                                state_reg <= S_ABORT;
                            end
                        end else begin
                            step_reg <= ST_SYNC; // R7
                            state_reg <= S_LOAD;
                        end
                    end
                end
                S_LOAD: begin
                    byte_reg <= 2'd0;
                    if (step_reg == ST_FAR) begin
                        far_reg <= far_word;
                    end
                    if (step_reg == ST_DATA && wcnt_reg != frame_words - 11'd1) begin
                        mem_rd <= 1'b1; // R4
                        mem_frame <= cur_frame;
                        mem_word <= wcnt_reg;
                        state_reg <= S_WAIT;
                    end else begin
                        shift_reg <= step_word;
                        state_reg <= S_SEND;
                    end
                end
                S_WAIT: begin
                    shift_reg <= mem_rdata;
                    state_reg <= S_SEND;
                end
                S_SEND: begin
                    if (tick_fall) begin
                        cfg_cs_n <= 1'b0;
                        cfg_wr_n <= 1'b0;
                        cfg_d_oe <= 1'b1;
                        cfg_d_out <= shift_reg[31:24];
                        shift_reg <= {shift_reg[23:0], 8'h00};
                        byte_reg <= byte_reg + 2'd1;
                        if (byte_reg == 2'd3) begin
                            state_reg <= S_NEXT;
                        end
                    end
                end
                S_NEXT: begin
                    state_reg <= S_LOAD;
                    if (step_reg == ST_DATA || step_reg == ST_DUMMY) begin
                        if (wcnt_reg == frame_words - 11'd1) begin
                            wcnt_reg <= 11'd0; // R11
                            step_reg <= step_reg + 4'd1;
                        end else begin
                            wcnt_reg <= wcnt_reg + 11'd1;
                        end
                    end else if (step_reg == ST_CHKCLR) begin
                        step_reg <= ST_ABORT2; // R13
                        abort_reg <= 3'd0;
                        state_reg <= S_ABORT;
                    end else begin
                        step_reg <= step_reg + 4'd1;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// file: testbench/frame_repair_chk.sv
`timescale 1ns/1ps
module frame_repair_chk (
    // Clock and reset
    input wire        core_clk,
    input wire        arst_n,
    // Watched ports
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        rb_done,
    input wire        mem_rd,
    input wire        busy,
    input wire        cfg_cclk,
    input wire        cfg_cs_n,
    input wire        cfg_wr_n,
    input wire [7:0]  cfg_d_out,
    input wire        cfg_d_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire      ab = !cfg_cs_n && cfg_wr_n;
    reg       cclk_q;
    reg [2:0] rises;
    // Rising config clocks seen during one abort
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cclk_q <= 1'b0;
            rises <= 3'd0;
        end else begin
            cclk_q <= cfg_cclk;
            if (!ab)
                rises <= 3'd0;
            else if (cfg_cclk && !cclk_q && rises != 3'd7)
                rises <= rises + 3'd1;
        end
    end
    sequence abort_done;
        $fell(ab);
    endsequence
    abort_len_a: assert property (abort_done |-> rises >= 3'd3)
        else $error("abort too short");
    abort_exit_a: assert property (abort_done |-> cfg_cs_n && cfg_wr_n)
        else $error("no deselect after abort");
    abort_quiet_a: assert property (ab |-> !cfg_d_oe)
        else $error("data driven during abort");
    sync_first_a: assert property ($rose(cfg_d_oe) |-> cfg_d_out == 8'haa && !cfg_wr_n)
        else $error("burst does not open with sync");
    pins_held_a: assert property ($rose(cfg_cclk) |-> $stable(cfg_d_out) && $stable(cfg_cs_n)
        && $stable(cfg_wr_n))
        else $error("port changed at clock rise");
    cclk_half_a: assert property ($rose(cfg_cclk) |=> cfg_cclk ##1 !cfg_cclk)
        else $error("config clock half period wrong");
    start_cause_a: assert property ($rose(busy) |-> $past(rb_done) || $past(rb_done, 2)
        || $past(reg_wr) || $past(reg_wr, 2))
        else $error("rewrite started without cause");
    idle_pins_a: assert property (!busy && !$past(busy) |-> cfg_cs_n && !cfg_d_oe && !mem_rd)
        else $error("port active while idle");
    mem_pulse_a: assert property (mem_rd |=> !mem_rd)
        else $error("memory read longer than one cycle");
    rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
endmodule

bind frame_repair_ctrl frame_repair_chk u_chk (.core_clk(core_clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rb_done(rb_done),
    .mem_rd(mem_rd), .busy(busy), .cfg_cclk(cfg_cclk), .cfg_cs_n(cfg_cs_n),
    .cfg_wr_n(cfg_wr_n), .cfg_d_out(cfg_d_out), .cfg_d_oe(cfg_d_oe));

// file: testbench/cfg_port_model.sv
`timescale 1ns/1ps
`include "frame_repair_defs.vh"
module cfg_port_model (
    // Configuration port
    input wire       cfg_cclk,
    input wire       cfg_cs_n,
    input wire       cfg_wr_n,
    input wire [7:0] cfg_d_out,
    input wire       cfg_d_oe
);
    reg [31:0] frame_pointer_reg = 32'h0;
    reg [31:0] word = 32'h0;
    reg [31:0] prev = 32'h0;
    reg [31:0] sum = 32'h0;
    reg [31:0] far_log [0:15];
    reg [31:0] hdr_log [0:15];
    reg [31:0] sum_log [0:15];
    integer    dcnt_log [0:15];
    integer    nb = 0, run = 0, aborts = 0, syncs = 0, wcfgs = 0, nfr = 0, dcnt = 0;
    reg        synced = 1'b0;
    reg        in_data = 1'b0;
    always @(posedge cfg_cclk) begin
        if (!cfg_cs_n && cfg_wr_n) begin
            run = run + 1;
            if (run == 3) begin
                aborts = aborts + 1;
                synced = 1'b0;
                in_data = 1'b0;
            end
        end else begin
            run = 0;
        end
        if (!cfg_cs_n && !cfg_wr_n) begin
            word = {word[23:0], cfg_d_out};
            nb = nb + 1;
            if (!synced) begin
                if (word == `SYNC_WORD) begin
                    synced = 1'b1;
                    nb = 0;
                    syncs = syncs + 1;
                    prev = 32'h0;
                end
            end else if (nb == 4) begin
                nb = 0;
                if (in_data && word == `CMD_HDR_WORD) begin
                    in_data = 1'b0;
                    dcnt_log[nfr] = dcnt;
                    sum_log[nfr] = sum;
                end else if (in_data) begin
                    dcnt = dcnt + 1;
                    sum = sum + word;
                end else if (prev == `FAR_HDR_WORD) begin
                    frame_pointer_reg = word;
                end else if (prev == `CMD_HDR_WORD && word == `WR_ENABLE_WORD) begin
                    wcfgs = wcfgs + 1;
                end else if (prev == `CMD_HDR_WORD && word == `CHECK_CLR_WORD) begin
                    far_log[nfr] = frame_pointer_reg;
                    nfr = nfr + 1;
                end else if (word[31:11] == 21'h060008) begin
                    hdr_log[nfr] = word;
                    in_data = 1'b1;
                    dcnt = 0;
                    sum = 32'h0;
                end
                prev = word;
            end
        end
    end
endmodule

// file: testbench/single_frame_seu_repair_tb.sv
`timescale 1ns/1ps
`include "frame_repair_defs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module single_frame_seu_repair_tb;
    localparam COLS = 4;
    reg         core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [31:0] reg_wdata = 32'h0;
    reg         rb_start = 0, rb_frame = 0, rb_mismatch = 0, rb_done = 0;
    wire [31:0] reg_rdata;
    wire [11:0] chk_addr, mem_frame;
    wire [10:0] mem_word;
    wire [7:0]  cfg_d_out;
    wire        mem_rd, cfg_cclk, cfg_cs_n, cfg_wr_n, cfg_d_oe, busy;
    // Frame memory, valid only while the read strobe stands
    wire [31:0] mem_rdata = mem_rd ? {9'h1a5, mem_frame, mem_word}
                                   : ~{9'h1a5, mem_frame, mem_word};
    integer     num_errors = 0, checks = 0, nbad, i, s, base, c;
    integer     bad [0:6] = '{7, 8, 199, 200, 307, 308, 361};
    frame_repair_ctrl #(.COLS(COLS)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rb_start(rb_start), .rb_frame(rb_frame),
        .rb_mismatch(rb_mismatch), .rb_done(rb_done), .chk_addr(chk_addr), .mem_rd(mem_rd),
        .mem_frame(mem_frame), .mem_word(mem_word), .mem_rdata(mem_rdata),
        .cfg_cclk(cfg_cclk), .cfg_cs_n(cfg_cs_n), .cfg_wr_n(cfg_wr_n),
        .cfg_d_out(cfg_d_out), .cfg_d_oe(cfg_d_oe), .busy(busy));
    cfg_port_model u_dev (.cfg_cclk(cfg_cclk), .cfg_cs_n(cfg_cs_n), .cfg_wr_n(cfg_wr_n),
        .cfg_d_out(cfg_d_out), .cfg_d_oe(cfg_d_oe));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    function [31:0] ptr(input integer n);
        integer mj, mn;
        begin
            mj = (n - COLS * 48 - 116) / 27 + COLS + 3;
            mn = (n - COLS * 48 - 116) % 27;
            if (n < 8) begin
                mj = 0;
                mn = n;
            end else if (n < COLS * 48 + 8) begin
                mj = (n - 8) / 48 + 1;
                mn = (n - 8) % 48;
            end else if (n < COLS * 48 + 116) begin
                mj = (n - COLS * 48 - 8) / 54 + COLS + 1;
                mn = (n - COLS * 48 - 8) % 54;
            end
            ptr = (mj << 17) | (mn << 9);
        end
    endfunction
    function [31:0] dsum(input integer f, input integer n);
        integer w;
        begin
            dsum = 32'h0;
            for (w = 0; w < n - 1; w++)
                dsum = dsum + {9'h1a5, f[11:0], w[10:0]};
        end
    endfunction
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1;
            `CHK(reg_rdata & m, e)
        end
    endtask
    task readback(input integer last, input integer all);
        integer n, k, hit;
        begin
            @(posedge core_clk);
            rb_start <= 1'b1;
            @(posedge core_clk);
            rb_start <= 1'b0;
            for (n = 0; n <= last; n++) begin
                hit = all;
                for (k = 0; k < nbad; k++)
                    if (bad[k] == n)
                        hit = 1;
                rb_frame <= 1'b1;
                rb_mismatch <= hit[0];
                @(posedge core_clk);
            end
            rb_frame <= 1'b0;
            rb_mismatch <= 1'b0;
            repeat (2) @(posedge core_clk);
            #1;
            `CHK(chk_addr, last[11:0] + 12'h1)
            @(posedge core_clk);
            rb_done <= 1'b1;
            @(posedge core_clk);
            rb_done <= 1'b0;
        end
    endtask
    task wait_idle(input e);
        integer t;
        begin
            t = 0;
            repeat (3) @(posedge core_clk);
            #1;
            `CHK(busy, e)
            while (busy !== 1'b0 && t < 20000) begin
                @(posedge core_clk);
                t++;
            end
            if (t >= 20000) begin
                num_errors++;
                $display("CHECK FAILED %0t busy never cleared", $time);
                conclude;
            end
        end
    endtask
    initial begin
        #3000000;
        num_errors++;
        conclude;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        // Every column kind at its boundaries, auto start
        nbad = 7;
        wr(`CTRL_OFS, 32'h1);
        readback(361, 0);
        wait_idle(1'b1);
        for (i = 0; i < 7; i++) begin
            `CHK(u_dev.far_log[i], ptr(bad[i]))
            `CHK(u_dev.hdr_log[i], `DATA_HDR_SMALL)
            `CHK(u_dev.dcnt_log[i], 84)
            `CHK(u_dev.sum_log[i], dsum(bad[i], 42))
        end
        `CHK(u_dev.aborts, 14)
        `CHK(u_dev.syncs, 7)
        `CHK(u_dev.wcfgs, 7)
        `CHK(u_dev.nfr, 7)
        rd(`REPAIRED_OFS, 32'hffff, 32'h7);
        rd(`LAST_PTR_OFS, 32'hffffffff, ptr(361));
        rd(`STATUS_OFS, 32'hf03, 32'h700);
        $display("test columns done");
        // Other sizes, manual start
        nbad = 1;
        for (s = 1; s < 4; s++) begin
            base = u_dev.nfr;
            c = (s == 1) ? 60 : 78;
            wr(`CTRL_OFS, s << 1);
            rd(`CTRL_OFS, 32'h7, s << 1);
            readback(9, 0);
            wait_idle(1'b0);
            wr(`CTRL_OFS, (s << 1) | 8);
            wait_idle(1'b1);
            `CHK(u_dev.hdr_log[base], 32'h30004000 | c)
            `CHK(u_dev.dcnt_log[base], 2 * c)
            `CHK(u_dev.sum_log[base], dsum(7, c))
        end
        $display("test sizes done");
        // Empty list and overflow
        nbad = 0;
        wr(`CTRL_OFS, 32'h1);
        readback(20, 0);
        wait_idle(1'b0);
        wr(`CTRL_OFS, 32'h0);
        readback(8, 1);
        rd(`STATUS_OFS, 32'hf03, 32'h802);
        wr(`CTRL_OFS, 32'h10);
        rd(`STATUS_OFS, 32'h3, 32'h0);
        rd(4'h2, 32'hffffffff, 32'h0);
        $display("test overflow done");
        conclude;
    end
endmodule
